/* logic/lbc_ctrl.sv */
// LCD blink, power-on state and clock source control with display timing and output levels
//
// How it works
// - Blink mode bit: 0 (reset) whole-display blink, 1 alternate bank blink.
// - Blink rate field 00 off (reset), 01/10/11 pick blink modes 1/2/3.
// - Blink period is 768, 1536 or 3072 active clock ticks per mode.
// - In 1:3 and 1:4 modes blinking is always whole-display blinking.
// - Alternate blink swaps output bank at blink rate in static and 1:2.
// - A change of the display enable bit reaches the outputs unless a whole-display blink phase blanks them.
// - After reset every output stands at the LCD supply level.
// - After reset the drive mode is 1:4 with one-third bias.
// - After reset blinking is off and both bank selectors are zero.
// - After reset data pointer and subaddress counter are zero.
// - After reset the display enable bit is clear.
// - Select pin low: internal oscillator runs and is driven out on clock pin.
// - Select pin high: clock pin edges time the frame and blink logic; registers and RAM stay on the core clock.
// - Output levels follow the latest drive mode and bias settings.
// - Half bias is accepted with 1:3 and 1:4 modes.
// - A display register holds the row data while it is driven.
// - One frame lasts 24 active clock ticks.
// - Display disabled drives every output to the LCD supply level.
// - Bank 1 selects row 2 (static) or rows 2-3 (1:2).
`timescale 1ns/1ps
module lbc_ctrl
   import lbc_pkg::*;
#(
   parameter int POR_CYCLES = POR_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        osc_sel,
   input  wire logic        clk_pin_i,
   output logic             clk_pin_o,
   output logic             clk_pin_oe,
   input  wire logic [2:0]  subaddr_pins,
   output logic      [7:0]  backplane_outputs,
   output logic      [63:0] segment_outputs
);
   // Pin synchronisers
   logic       osc_s1_ff, osc_s2_ff, ck_s1_ff, ck_s2_ff, ck_s3_ff;
   logic [2:0] sa_s1_ff, sa_s2_ff;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_s1_ff <= 1'h0;
         osc_s2_ff <= 1'h0;
         ck_s1_ff  <= 1'h0;
         ck_s2_ff  <= 1'h0;
         ck_s3_ff  <= 1'h0;
         sa_s1_ff  <= 3'h0;
         sa_s2_ff  <= 3'h0;
      end else begin
         osc_s1_ff <= osc_sel;
         osc_s2_ff <= osc_s1_ff;
         ck_s1_ff  <= clk_pin_i;
         ck_s2_ff  <= ck_s1_ff;
         ck_s3_ff  <= ck_s2_ff;
         sa_s1_ff  <= subaddr_pins;
         sa_s2_ff  <= sa_s1_ff;
      end
   end

   // Configuration registers
   logic       disp_en_ff, bias_half_ff, ibank_ff, obank_ff, blink_mode_select_ff;
   logic [1:0] mode_ff, blink_rate_field_ff;
   logic [4:0] ptr_ff;
   logic [2:0] suba_ff;
   logic       nxt_disp_en, nxt_bias_half, nxt_ibank, nxt_obank, nxt_blink_mode_select;
   logic [1:0] nxt_mode, nxt_blink_rate_field;
   logic [4:0] nxt_ptr;
   logic [2:0] nxt_suba;

   always_comb begin
      nxt_disp_en   = disp_en_ff;
      nxt_bias_half = bias_half_ff;
      nxt_mode      = mode_ff;
      nxt_ibank     = ibank_ff;
      nxt_obank     = obank_ff;
      nxt_blink_mode_select = blink_mode_select_ff;
      nxt_blink_rate_field  = blink_rate_field_ff;
      nxt_ptr       = ptr_ff;
      nxt_suba      = suba_ff;
      if (reg_wr) begin
         case (reg_addr)
            REG_MODE: begin
               nxt_disp_en   = reg_wdata[MODE_E_POS];
               nxt_bias_half = reg_wdata[MODE_B_POS];
               nxt_mode      = reg_wdata[1:0];
            end
            REG_BANK: begin
               nxt_ibank = reg_wdata[BANK_I_POS];
               nxt_obank = reg_wdata[BANK_O_POS];
            end
            REG_BLINK: begin
               nxt_blink_mode_select = reg_wdata[BLINK_MODE_POS];
               nxt_blink_rate_field  = reg_wdata[1:0];
            end
            REG_PTR:  nxt_ptr = reg_wdata[4:0];
            REG_SUBA: nxt_suba = reg_wdata[2:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         disp_en_ff   <= 1'h0;
         bias_half_ff <= RST_BIAS;
         mode_ff      <= RST_MODE;
         ibank_ff     <= 1'h0;
         obank_ff     <= 1'h0;
         blink_mode_select_ff <= 1'h0;
         blink_rate_field_ff  <= RST_RATE;
         ptr_ff       <= 5'h0;
         suba_ff      <= 3'h0;
      end else begin
         disp_en_ff   <= nxt_disp_en;
         bias_half_ff <= nxt_bias_half;
         mode_ff      <= nxt_mode;
         ibank_ff     <= nxt_ibank;
         obank_ff     <= nxt_obank;
         blink_mode_select_ff <= nxt_blink_mode_select;
         blink_rate_field_ff  <= nxt_blink_rate_field;
         ptr_ff       <= nxt_ptr;
         suba_ff      <= nxt_suba;
      end
   end

   // Display RAM write, stored only when the subaddress counter matches the pins
   logic       ram_we;
   logic [3:0] ram_mask, ram_wdata;
   logic [31:0] ram_rd;
   logic [1:0]  ram_row;

   always_comb begin
      ram_we = reg_wr && (reg_addr == REG_DATA) && (suba_ff == sa_s2_ff);
      case (mode_ff)
         M_STATIC: begin
            ram_mask  = ibank_ff ? 4'h4 : 4'h1;
            ram_wdata = {4{reg_wdata[0]}};
         end
         M_1TO2: begin
            ram_mask  = ibank_ff ? 4'hc : 4'h3;
            ram_wdata = {2{reg_wdata[1:0]}};
         end
         M_1TO3: begin
            ram_mask  = 4'h7;
            ram_wdata = reg_wdata[3:0];
         end
         default: begin
            ram_mask  = 4'hf;
            ram_wdata = reg_wdata[3:0];
         end
      endcase
   end

   // Active clock: internal divider or external pin edges
   logic       osc_ext_ff, clk_out_ff, tick;
   logic [3:0] osc_cnt_ff, nxt_osc_cnt;
   logic       nxt_clk_out, osc_wrap;
   logic [4:0] slot_ff, nxt_slot;
   logic [1:0] row_ff, nxt_row;
   logic       pol_ff, nxt_pol;
   logic [10:0] blk_cnt_ff, nxt_blk_cnt;
   logic        blk_ph_ff, nxt_blk_ph;
   logic [31:0] disp_ff, nxt_disp;
   logic [16:0] por_cnt_ff, nxt_por_cnt;

   always_comb begin
      osc_wrap    = (osc_cnt_ff == OSC_HALF - 4'h1);
      nxt_osc_cnt = osc_wrap ? 4'h0 : osc_cnt_ff + 4'h1;
      nxt_clk_out = osc_wrap ? ~clk_out_ff : clk_out_ff;
      tick        = osc_ext_ff ? (ck_s2_ff && !ck_s3_ff)
                               : (osc_wrap && !clk_out_ff);
      nxt_slot = slot_ff;
      nxt_row  = row_ff;
      nxt_pol  = pol_ff;
      if (tick) begin
         if (slot_ff >= lbc_slot_len(mode_ff) - 5'h1) begin
            nxt_slot = 5'h0;
            if ({1'h0, row_ff} >= lbc_nbp(mode_ff) - 3'h1) begin
               nxt_row = 2'h0;
               nxt_pol = ~pol_ff;
            end else begin
               nxt_row = row_ff + 2'h1;
            end
         end else begin
            nxt_slot = slot_ff + 5'h1;
         end
      end
      nxt_blk_cnt = blk_cnt_ff;
      nxt_blk_ph  = blk_ph_ff;
      if (blink_rate_field_ff == 2'h0) begin
         nxt_blk_cnt = 11'h0;
         nxt_blk_ph  = 1'h0;
      end else if (tick) begin
         if (blk_cnt_ff >= lbc_blink_half(blink_rate_field_ff) - 11'h1) begin
            nxt_blk_cnt = 11'h0;
            nxt_blk_ph  = ~blk_ph_ff;
         end else begin
            nxt_blk_cnt = blk_cnt_ff + 11'h1;
         end
      end
      // Row data settles in the RAM read register before the next tick latches it
      nxt_disp    = (tick && slot_ff == 5'h0) ? ram_rd : disp_ff;
      nxt_por_cnt = (por_cnt_ff == 17'(POR_CYCLES)) ? por_cnt_ff : por_cnt_ff + 17'h1;
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_ext_ff <= 1'h0;
         clk_out_ff <= 1'h0;
         osc_cnt_ff <= 4'h0;
         slot_ff    <= 5'h0;
         row_ff     <= 2'h0;
         pol_ff     <= 1'h0;
         blk_cnt_ff <= 11'h0;
         blk_ph_ff  <= 1'h0;
         disp_ff    <= 32'h0;
         por_cnt_ff <= 17'h0;
      end else begin
         osc_ext_ff <= osc_s2_ff;
         clk_out_ff <= nxt_clk_out;
         osc_cnt_ff <= nxt_osc_cnt;
         slot_ff    <= nxt_slot;
         row_ff     <= nxt_row;
         pol_ff     <= nxt_pol;
         blk_cnt_ff <= nxt_blk_cnt;
         blk_ph_ff  <= nxt_blk_ph;
         disp_ff    <= nxt_disp;
         por_cnt_ff <= nxt_por_cnt;
      end
   end

   // Bank selection and blanking
   logic alt_ok, eff_obank, blank;

   always_comb begin
      alt_ok    = blink_mode_select_ff && (blink_rate_field_ff != 2'h0)
                  && (mode_ff == M_STATIC || mode_ff == M_1TO2);
      eff_obank = obank_ff ^ (alt_ok && blk_ph_ff);
      blank     = !disp_en_ff || ((blink_rate_field_ff != 2'h0) && !alt_ok && blk_ph_ff);
      case (mode_ff)
         M_STATIC: ram_row = eff_obank ? 2'h2 : 2'h0;
         M_1TO2:   ram_row = {eff_obank, row_ff[0]};
         default:  ram_row = row_ff;
      endcase
   end

   lbc_disp_ram u_ram (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .wr_en    (ram_we),
      .wr_col   (ptr_ff),
      .wr_mask  (ram_mask),
      .wr_data  (ram_wdata),
      .rd_row   (ram_row),
      .rd_data  (ram_rd)
   );

   // Output level selection
   logic [7:0]  bp_ff, nxt_bp;
   logic [63:0] seg_ff, nxt_seg;
   logic [31:0] rdata_ff, nxt_rdata;
   logic        clk_oe_ff;
   logic [1:0]  unsel_lvl, sel_lvl, on_lvl, idx;

   always_comb begin
      sel_lvl   = pol_ff ? LVL_VSS : LVL_LCD;
      on_lvl    = pol_ff ? LVL_LCD : LVL_VSS;
      unsel_lvl = bias_half_ff ? LVL_MID : (pol_ff ? LVL_HI : LVL_LO);
      nxt_bp    = '0;
      nxt_seg   = '0;
      for (int i = 0; i < 4; i++) begin
         idx = 2'(i);
         if (mode_ff == M_1TO3 && i == 3) begin
            idx = 2'h1;
         end
         if (mode_ff == M_STATIC || (mode_ff == M_1TO2 ? idx[0] == row_ff[0] : idx == row_ff)) begin
            nxt_bp[2*i +: 2] = sel_lvl;
         end else begin
            nxt_bp[2*i +: 2] = bias_half_ff ? LVL_MID : (pol_ff ? LVL_LO : LVL_HI);
         end
      end
      for (int s = 0; s < 32; s++) begin
         if (mode_ff == M_STATIC) begin
            nxt_seg[2*s +: 2] = disp_ff[s] ? on_lvl : sel_lvl;
         end else begin
            nxt_seg[2*s +: 2] = disp_ff[s] ? on_lvl : unsel_lvl;
         end
      end
      if (blank) begin
         nxt_bp  = {4{LVL_LCD}};
         nxt_seg = {32{LVL_LCD}};
      end
      nxt_rdata = 32'h0;
      if (reg_rd) begin
         case (reg_addr)
            REG_MODE:   nxt_rdata = {28'h0, disp_en_ff, bias_half_ff, mode_ff};
            REG_BANK:   nxt_rdata = {30'h0, ibank_ff, obank_ff};
            REG_BLINK:  nxt_rdata = {29'h0, blink_mode_select_ff, blink_rate_field_ff};
            REG_PTR:    nxt_rdata = {27'h0, ptr_ff};
            REG_SUBA:   nxt_rdata = {29'h0, suba_ff};
            REG_STATUS: nxt_rdata = {26'h0, por_cnt_ff == 17'(POR_CYCLES), row_ff,
                                     eff_obank, osc_ext_ff, blk_ph_ff};
            default:    nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bp_ff     <= {4{LVL_LCD}};
         seg_ff    <= {32{LVL_LCD}};
         rdata_ff  <= 32'h0;
         clk_oe_ff <= 1'h0;
      end else begin
         bp_ff     <= nxt_bp;
         seg_ff    <= nxt_seg;
         rdata_ff  <= nxt_rdata;
         clk_oe_ff <= !osc_ext_ff;
      end
   end

   assign backplane_outputs = bp_ff;
   assign segment_outputs   = seg_ff;
   assign reg_rdata         = rdata_ff;
   assign clk_pin_o         = clk_out_ff;
   assign clk_pin_oe        = clk_oe_ff;

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_enable_write;
      reg_wr && reg_addr == REG_MODE && reg_wdata[MODE_E_POS];
   endsequence
   property p_enable_apply;
      s_enable_write |=> disp_en_ff ##1 (!blank || blink_rate_field_ff != 2'h0);
   endproperty
   a_enable_apply: assert property (p_enable_apply) else $error("enable write not applied");
   property p_disabled_blank;
      !disp_en_ff |=> backplane_outputs == {4{LVL_LCD}} && segment_outputs == {32{LVL_LCD}};
   endproperty
   a_disabled_blank: assert property (p_disabled_blank) else $error("disabled not blank");
   property p_blink_off;
      blink_rate_field_ff == 2'h0 |=> !blk_ph_ff && blk_cnt_ff == 11'h0;
   endproperty
   a_blink_off: assert property (p_blink_off) else $error("blink runs while off");
   property p_blink_toggle;
      tick && blink_rate_field_ff == 2'h1 && blk_cnt_ff == 11'h17f
         && $stable(blink_rate_field_ff) |=> blk_ph_ff != $past(blk_ph_ff);
   endproperty
   a_blink_toggle: assert property (p_blink_toggle) else $error("blink half period wrong");
   property p_no_alt_in_mux;
      (mode_ff == M_1TO3 || mode_ff == M_1TO4) |-> eff_obank == obank_ff;
   endproperty
   a_no_alt_in_mux: assert property (p_no_alt_in_mux) else $error("bank swap in 1:3/1:4");
   property p_frame_end;
      tick && mode_ff == M_1TO4 && slot_ff == 5'h5 && row_ff == 2'h3
         |=> pol_ff != $past(pol_ff) && row_ff == 2'h0;
   endproperty
   a_frame_end: assert property (p_frame_end) else $error("frame not 24 ticks");
   property p_disp_hold;
      !tick |=> $stable(disp_ff);
   endproperty
   a_disp_hold: assert property (p_disp_hold) else $error("display register changed");
   property p_clk_dir;
      osc_ext_ff ##1 osc_ext_ff |=> !clk_pin_oe;
   endproperty
   a_clk_dir: assert property (p_clk_dir) else $error("clock pin driven in external mode");
   property p_suba_gate;
      reg_wr && reg_addr == REG_DATA && suba_ff != sa_s2_ff |-> !ram_we;
   endproperty
   a_suba_gate: assert property (p_suba_gate) else $error("write with subaddress mismatch");
endmodule : lbc_ctrl

/* pkg/lbc_pkg.sv */
// Constants, encodings and helper functions of the LCD blink, reset and clock control
package lbc_pkg;
   // Register map, byte offsets
   localparam logic [7:0] REG_MODE   = 8'h00;
   localparam logic [7:0] REG_BANK   = 8'h04;
   localparam logic [7:0] REG_BLINK  = 8'h08;
   localparam logic [7:0] REG_PTR    = 8'h0c;
   localparam logic [7:0] REG_SUBA   = 8'h10;
   localparam logic [7:0] REG_DATA   = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   // Field positions
   localparam int MODE_E_POS = 3;
   localparam int MODE_B_POS = 2;
   localparam int BANK_I_POS = 1;
   localparam int BANK_O_POS = 0;
   localparam int BLINK_MODE_POS = 2;
   // Drive modes and reset values
   localparam logic [1:0] M_STATIC = 2'h1;
   localparam logic [1:0] M_1TO2   = 2'h2;
   localparam logic [1:0] M_1TO3   = 2'h3;
   localparam logic [1:0] M_1TO4   = 2'h0;
   localparam logic [1:0] RST_MODE = M_1TO4;
   localparam logic       RST_BIAS = 1'h0;
   localparam logic [1:0] RST_RATE = 2'h0;
   // Drive level codes on each output pin
   localparam logic [1:0] LVL_VSS = 2'h0;
   localparam logic [1:0] LVL_LO  = 2'h1;
   localparam logic [1:0] LVL_HI  = 2'h2;
   localparam logic [1:0] LVL_LCD = 2'h3;
   localparam logic [1:0] LVL_MID = LVL_LO;
   // Timing
   localparam int         CORE_MHZ      = 125;
   localparam int         FRAME_DIV     = 24;
   localparam logic [3:0] OSC_HALF      = 4'h2;
   localparam int         BLINK_DIV_1   = 768;
   localparam int         BLINK_DIV_2   = 1536;
   localparam int         BLINK_DIV_3   = 3072;
   localparam int         POR_TIME_US   = 1000;
   localparam int         POR_CYC       = POR_TIME_US * CORE_MHZ;

   // Active backplanes of a drive mode
   function automatic logic [2:0] lbc_nbp(input logic [1:0] m);
      case (m)
         M_STATIC: lbc_nbp = 3'h1;
         M_1TO2:   lbc_nbp = 3'h2;
         M_1TO3:   lbc_nbp = 3'h3;
         default:  lbc_nbp = 3'h4;
      endcase
   endfunction : lbc_nbp

   // Clock ticks per backplane slot, one frame is FRAME_DIV ticks
   function automatic logic [4:0] lbc_slot_len(input logic [1:0] m);
      lbc_slot_len = 5'(FRAME_DIV / int'(lbc_nbp(m)));
   endfunction : lbc_slot_len

   // Clock ticks per blink half period
   function automatic logic [10:0] lbc_blink_half(input logic [1:0] rate);
      case (rate)
         2'h1:    lbc_blink_half = 11'(BLINK_DIV_1 / 2);
         2'h2:    lbc_blink_half = 11'(BLINK_DIV_2 / 2);
         2'h3:    lbc_blink_half = 11'(BLINK_DIV_3 / 2);
         default: lbc_blink_half = 11'h1;
      endcase
   endfunction : lbc_blink_half
endpackage : lbc_pkg

/* logic/lbc_disp_ram.sv */
// Display RAM, four rows of 32 columns, column writes with row mask, registered row read
`timescale 1ns/1ps
module lbc_disp_ram
   import lbc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [4:0]  wr_col,
   input  wire logic [3:0]  wr_mask,
   input  wire logic [3:0]  wr_data,
   input  wire logic [1:0]  rd_row,
   output logic      [31:0] rd_data
);
   logic [31:0] mem [4];
   logic [31:0] rd_data_ff;

   always_ff @(posedge core_clk) begin
      for (int r = 0; r < 4; r++) begin
         if (wr_en && wr_mask[r]) begin
            mem[r][wr_col] <= wr_data[r];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data_ff <= 32'h0;
      end else begin
         rd_data_ff <= mem[rd_row];
      end
   end

   assign rd_data = rd_data_ff;
endmodule : lbc_disp_ram

/* tb/lbc_clk_src.sv */
// Far-side clock source that feeds the shared clock pin
`timescale 1ns/1ps
module lbc_clk_src (
   input  wire logic [7:0] half_ns,
   output logic            ext_clk
);
   // Never stops, so the device always has ticks once it switches to the pin
   initial begin
      ext_clk = 1'b0;
      #3;
      forever begin
         #(half_ns);
         ext_clk = ~ext_clk;
      end
   end
endmodule : lbc_clk_src

/* tb/lbc_ctrl_tb.sv */
// Self-checking bench of the LCD blink, power-on and clock source control
`timescale 1ns/1ps
module lbc_ctrl_tb
   import lbc_pkg::*;
;
   logic        core_clk;
   logic        rst_n;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic        osc_sel;
   logic        clk_pin_i;
   logic        clk_pin_o;
   logic        clk_pin_oe;
   logic [2:0]  subaddr_pins;
   logic [7:0]  bp;
   logic [63:0] seg;
   logic [7:0]  half_ns;
   logic        ext_clk;
   logic        blank;
   logic [31:0] r;
   logic [31:0] q;
   logic [7:0]  a;
   logic        ob;
   logic        p;
   logic [7:0]  atab [7];
   int          n_fail;
   int          num_checks;
   int          i;
   int          n;
   int          seen;

   // Device wins the pin while it drives, else the far-side source does
   assign clk_pin_i = clk_pin_oe ? clk_pin_o : ext_clk;
   assign blank     = (bp === 8'hff) && (seg === {64{1'b1}});

   lbc_ctrl #(.POR_CYCLES(50)) DUT (
      .core_clk          (core_clk),
      .rst_n             (rst_n),
      .reg_addr          (reg_addr),
      .reg_wdata         (reg_wdata),
      .reg_wr            (reg_wr),
      .reg_rd            (reg_rd),
      .reg_rdata         (reg_rdata),
      .osc_sel           (osc_sel),
      .clk_pin_i         (clk_pin_i),
      .clk_pin_o         (clk_pin_o),
      .clk_pin_oe        (clk_pin_oe),
      .subaddr_pins      (subaddr_pins),
      .backplane_outputs (bp),
      .segment_outputs   (seg)
   );

   lbc_clk_src SRC (
      .half_ns (half_ns),
      .ext_clk (ext_clk)
   );

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic end_sim();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : end_sim

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp, input string m);
      num_checks++;
      if (got != exp) begin
         n_fail++;
         $display("ERROR %0t %s got %0d exp %0d", $time, m, got, exp);
      end
   endtask : chk_cnt

   task automatic tmo();
      n_fail++;
      $display("ERROR %0t wait limit used up", $time);
      end_sim();
   endtask : tmo

   // Sample just after the edge so that registered outputs have settled
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr     <= ad;
      reg_wdata    <= d;
      reg_wr       <= 1'b1;
      @(posedge core_clk);
      reg_wr       <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] ad, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   function automatic logic [31:0] rmask(input logic [7:0] ad);
      case (ad)
         REG_MODE:  rmask = 32'hf;
         REG_BANK:  rmask = 32'h3;
         REG_BLINK: rmask = 32'h7;
         REG_PTR:   rmask = 32'h1f;
         REG_SUBA:  rmask = 32'h7;
         default:   rmask = 32'h0;
      endcase
   endfunction : rmask

   // Core cycles in one blink half period for a rate code
   function automatic int half_cyc(input int rate);
      int dv;
      dv = (rate == 1) ? BLINK_DIV_1 : (rate == 2) ? BLINK_DIV_2 : BLINK_DIV_3;
      half_cyc = dv * int'(OSC_HALF);
   endfunction : half_cyc

   task automatic blink_run(input int hc);
      int t;
      for (t = 0; blank && t < 7000; t++) tick();
      if (t >= 7000) tmo();
      for (t = 0; !blank && t < 7000; t++) tick();
      if (t >= 7000) tmo();
      for (t = 0; blank && t < 7000; t++) tick();
      chk_cnt(t, hc, "blank half");
      for (t = 0; !blank && t < 7000; t++) tick();
      chk_cnt(t, hc, "shown half");
   endtask : blink_run

   // Polarity flips every frame, so the backplanes repeat after two frames
   task automatic frame_chk(input int fc);
      logic [7:0] b0;
      tick();
      b0 = bp;
      repeat (fc) tick();
      chk_val(32'(bp !== b0), 32'h1, "frame flip");
      repeat (fc) tick();
      chk_val({24'h0, bp}, {24'h0, b0}, "frame repeat");
   endtask : frame_chk

   task automatic hi_cnt(output int c);
      c = 0;
      repeat (200) begin
         tick();
         for (int k = 0; k < 4; k++) c += (bp[2*k+:2] === LVL_HI);
      end
   endtask : hi_cnt

   initial begin
      rst_n = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      osc_sel = 1'b0;
      subaddr_pins = 3'h0;
      half_ns = 8'h28;
      n_fail = 0;
      num_checks = 0;
      atab = '{REG_MODE, REG_BANK, REG_BLINK, REG_PTR, REG_SUBA, REG_DATA, 8'h1c};
      void'($urandom(36365));
      repeat (6) tick();
      chk_val({bp, seg[23:0]}, 32'hffffffff, "blank in reset");
      chk_val(32'(clk_pin_oe), 32'h0, "pin driven in reset");
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      for (i = 0; i < 5; i++) begin
         rd(atab[i], r);
         chk_val(r, 32'h0, "reset value");
      end
      chk_val(32'(blank), 32'h1, "blank after reset");
      rd(REG_STATUS, r);
      chk_val(32'(r[5]), 32'h0, "wait flag early");
      tick();
      chk_val(reg_rdata, 32'h0, "read data hold");
      repeat (60) tick();
      rd(REG_STATUS, r);
      chk_val(32'(r[5]), 32'h1, "wait flag late");
      // Internal oscillator drives the pin
      chk_val(32'(clk_pin_oe), 32'h1, "pin drive");
      n = 0;
      p = clk_pin_o;
      repeat (16) begin
         tick();
         n += (clk_pin_o !== p);
         p = clk_pin_o;
      end
      chk_cnt(n, 16 / int'(OSC_HALF), "osc toggles");
      wr(REG_BLINK, 32'h0);
      wr(REG_MODE, 32'h8);
      frame_chk(FRAME_DIV * 2 * int'(OSC_HALF));
      for (i = 0; i < 4; i++) begin
         wr(REG_MODE, {28'h0, i[0], 3'h0});
         tick();
         chk_val(32'(blank), 32'(!i[0]), "enable edge");
      end
      wr(REG_MODE, 32'hc);
      hi_cnt(n);
      chk_cnt(n, 0, "half bias levels");
      wr(REG_MODE, 32'h8);
      hi_cnt(n);
      chk_cnt(32'(n > 0), 1, "third bias levels");
      for (i = 1; i < 4; i++) begin
         wr(REG_BLINK, {29'h0, i[0], i[1:0]});
         blink_run(half_cyc(i));
      end
      wr(REG_BLINK, 32'h0);
      repeat (2) tick();
      n = 0;
      repeat (400) begin
         tick();
         n += blank;
      end
      chk_cnt(n, 0, "blink off");
      for (i = 0; i < 2; i++) begin
         ob = 1'($urandom);
         wr(REG_MODE, i ? 32'ha : 32'h9);
         wr(REG_BANK, {30'h0, ~ob, ob});
         wr(REG_BLINK, 32'h5);
         seen = 0;
         repeat (8) begin
            repeat ($urandom_range(900, 400)) tick();
            rd(REG_STATUS, r);
            chk_val(32'(r[2]), 32'(r[0] ^ ob), "alternate bank");
            seen |= 1 << r[0];
         end
         chk_cnt(seen, 3, "blink phases");
      end
      for (i = 0; i < 16; i++) begin
         a = (i < 2) ? REG_MODE : atab[$urandom_range(6, 0)];
         r = (i == 0) ? 32'h7 : (i == 1) ? 32'h4 : $urandom;
         wr(a, r);
         rd(a, q);
         chk_val(q, r & rmask(a), "readback");
      end
      // Static drive: an on bit in the lower bank and an off bit in the upper bank of one column
      @(posedge core_clk);
      subaddr_pins <= 3'($urandom);
      a = 8'($urandom_range(31, 0));
      wr(REG_BLINK, 32'h0);
      wr(REG_MODE, 32'h9);
      wr(REG_SUBA, {29'h0, subaddr_pins});
      wr(REG_PTR, {24'h0, a});
      for (i = 0; i < 4; i++) begin
         wr(REG_BANK, {30'h0, i[0], i[1]});
         if (i < 2) wr(REG_DATA, {31'h0, ~i[0]});
         repeat (250) tick();
         // An on segment stands in antiphase to the static backplane
         chk_val(32'(seg[2*a+:2] !== bp[1:0]), 32'(!i[1]), "bank data");
      end
      // External clock on the pin, one tick every 10 core cycles
      wr(REG_BLINK, 32'h0);
      wr(REG_MODE, 32'h8);
      @(posedge core_clk);
      osc_sel <= 1'b1;
      repeat (8) tick();
      chk_val(32'(clk_pin_oe), 32'h0, "pin released");
      rd(REG_STATUS, r);
      chk_val(32'(r[1]), 32'h1, "external source");
      frame_chk(FRAME_DIV * 10);
      @(posedge core_clk);
      osc_sel <= 1'b0;
      repeat (8) tick();
      chk_val(32'(clk_pin_oe), 32'h1, "pin driven again");
      end_sim();
   end
endmodule : lbc_ctrl_tb
